// ===== common/branch_exec_map.svh
`ifndef BRANCH_EXEC_MAP_SVH
`define BRANCH_EXEC_MAP_SVH

// Opcode patterns
`define OPC_NOT_ZERO_UPPER 8'hE1
`define OPC_NO_OVF_UPPER   8'hE5
`define OPC_ALWAYS_TOP5    5'h1A
// Field positions
`define UPPER_MSB       15
`define UPPER_LSB       8
`define TOP5_MSB        15
`define TOP5_LSB        11
`define SHORT_OFF_MSB   7
`define LONG_OFF_MSB    10
// Status flag positions
`define FLAG_ZERO_BIT   2
`define FLAG_OVF_BIT    3
// Reset values
`define PC_RESET        21'h000000
`define PHASE_RESET     2'h0
// Instruction word step in bytes
`define WORD_STEP       21'h000002

`endif

// ===== common/branch_exec_pkg.sv
package branch_exec_pkg;
	typedef logic [20:0] pc_t;
	typedef logic [15:0] word_t;

	typedef enum logic [1:0] {
		op_none   = 2'b00,
		op_not_zero = 2'b01,
		op_no_ovf   = 2'b10,
		op_always   = 2'b11
	} branch_op_e;

	typedef enum logic [1:0] {
		st_exec   = 2'b00,
		st_flush  = 2'b01
	} cycle_state_e;
endpackage : branch_exec_pkg

// ===== common/branch_decode_if.sv
`timescale 1ns/1ps
interface branch_decode_if;
	import branch_exec_pkg::*;
	logic [15:0]  instr;
	logic [4:0]   status;
	branch_op_e   op;
	logic         taken;
	logic [20:0]  offset2;

	modport decoder (input instr, input status, output op, output taken, output offset2);
	modport core    (output instr, output status, input op, input taken, input offset2);
endinterface : branch_decode_if

// ===== logic/branch_decode.sv
`timescale 1ns/1ps
`include "branch_exec_map.svh"
module branch_decode
	import branch_exec_pkg::*;
(
	// Decode channel
	branch_decode_if.decoder dec
);
	// Opcode and condition decode
	always_comb begin
		dec.op      = op_none;
		dec.taken   = 1'b0;
		dec.offset2 = '0;
		if (dec.instr[`UPPER_MSB:`UPPER_LSB] == `OPC_NOT_ZERO_UPPER) begin
			dec.op      = op_not_zero;
			dec.taken   = ~dec.status[`FLAG_ZERO_BIT];
			dec.offset2 = {{12{dec.instr[`SHORT_OFF_MSB]}},
				dec.instr[`SHORT_OFF_MSB:0], 1'b0};
		end else if (dec.instr[`UPPER_MSB:`UPPER_LSB] == `OPC_NO_OVF_UPPER) begin
			dec.op      = op_no_ovf;
			dec.taken   = ~dec.status[`FLAG_OVF_BIT];
			dec.offset2 = {{12{dec.instr[`SHORT_OFF_MSB]}},
				dec.instr[`SHORT_OFF_MSB:0], 1'b0};
		end else if (dec.instr[`TOP5_MSB:`TOP5_LSB] == `OPC_ALWAYS_TOP5) begin
			dec.op      = op_always;
			dec.taken   = 1'b1;
			dec.offset2 = {{9{dec.instr[`LONG_OFF_MSB]}},
				dec.instr[`LONG_OFF_MSB:0], 1'b0};
		end
	end
endmodule : branch_decode

// ===== logic/relative_branch_execution.sv
`timescale 1ns/1ps
`include "branch_exec_map.svh"
module relative_branch_execution
	import branch_exec_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Instruction from fetch, valid at phase one of each executing cycle
	input  wire logic [15:0] instr_word,
	input  wire logic        instr_valid,
	// Status flags in and out
	input  wire logic [4:0]  status_in,
	output logic      [4:0]  status_out,
	// Program counter
	output logic      [20:0] pc_value,
	output logic             pc_write,
	// Sequencing
	output logic      [1:0]  q_phase,
	output logic             flush_cycle,
	output logic             cycle_done,
	output logic             is_branch
);
	// Everything the sequencer remembers
	typedef struct packed {
		logic [1:0]   phase;
		cycle_state_e cstate;
		pc_t          pc;
		pc_t          target;
		logic         take;
		logic         held;
		word_t        literal;
		logic         pcw;
	} state_s;

	// Registered state and its next value
	state_s          state_reg;
	state_s          state_next;

	// Decode channel to the opcode decoder
	branch_decode_if dif ();

	// Phase strobes of the current instruction cycle
	logic [3:0]      phase_hot;
	logic            live_cycle;
	logic            at_fetch;
	logic            at_advance;
	logic            at_evaluate;
	logic            at_commit;
	logic            branch_hit;

	// True when the phase counter stands at the wanted quadrature phase
	function automatic logic phase_match(input logic [1:0] ph, input logic [1:0] want);
		phase_match = ph == want;
	endfunction : phase_match

	// Counter plus a step; the carry out of the top bit wraps away
	function automatic pc_t add_offset(input pc_t base, input pc_t step);
		logic [21:0] sum;
		sum = {1'b0, base} + {1'b0, step};
		add_offset = sum[20:0];
	endfunction : add_offset

	// Decoder sees the held literal word
	assign dif.instr  = state_reg.literal;
	assign dif.status = status_in;

	// Opcode, condition and offset decode
	branch_decode i_branch_decode (
		.dec (dif.decoder)
	);

	// One strobe per quadrature phase
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_phase
			assign phase_hot[g] = phase_match(state_reg.phase, 2'(g));
		end
	endgenerate

	// Only an executing cycle may fetch, advance or branch
	assign live_cycle  = state_reg.cstate == st_exec;
	assign at_fetch    = live_cycle && phase_hot[0];
	assign at_advance  = live_cycle && phase_hot[1];
	assign at_evaluate = live_cycle && phase_hot[2];
	assign at_commit   = live_cycle && phase_hot[3];

	// A real word is held and decodes as one of the three branches
	assign branch_hit  = state_reg.held && dif.op != op_none;

	// Four-phase sequencer and counter update
	always_comb begin
		state_next       = state_reg;
		state_next.pcw   = 1'b0;
		state_next.phase = state_reg.phase + 2'h1;
		case (state_reg.phase)
			2'h0: begin
				// Latch the word, or an empty slot so an old word never decodes again
				if (at_fetch) begin
					state_next.held    = instr_valid;
					state_next.literal = instr_valid ? instr_word : 16'h0000;
				end
			end

			2'h1: begin
				// Counter moves past the current word
				if (at_advance) begin
					state_next.pc = add_offset(state_reg.pc, `WORD_STEP);
				end
			end

			2'h2: begin
				// Flag test and target from the incremented counter
				if (at_evaluate) begin
					state_next.take   = branch_hit && dif.taken;
					state_next.target = add_offset(state_reg.pc, dif.offset2);
				end
			end

			2'h3: begin
				// Write the counter and book the no-op cycle
				if (at_commit && state_reg.take) begin
					state_next.pc     = state_reg.target;
					state_next.pcw    = 1'b1;
					state_next.cstate = st_flush;
				end else begin
					state_next.cstate = st_exec;
				end
				state_next.take = 1'b0;
				// A consumed word is dropped so it cannot branch twice
				if (state_reg.cstate == st_flush || state_reg.take) begin
					state_next.literal = 16'h0000;
					state_next.held    = 1'b0;
				end
			end

			default: begin
				state_next.phase = `PHASE_RESET;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg.phase   <= `PHASE_RESET;
			state_reg.cstate  <= st_exec;
			state_reg.pc      <= `PC_RESET;
			state_reg.target  <= `PC_RESET;
			state_reg.take    <= 1'b0;
			state_reg.held    <= 1'b0;
			state_reg.literal <= 16'h0000;
			state_reg.pcw     <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Flags pass through untouched
	assign status_out  = status_in;

	// Counter and its write strobe
	assign pc_value    = state_reg.pc;
	assign pc_write    = state_reg.pcw;

	// Sequencing outputs
	assign q_phase     = state_reg.phase;
	assign flush_cycle = state_reg.cstate == st_flush;
	assign cycle_done  = phase_hot[3];
	assign is_branch   = branch_hit;
endmodule : relative_branch_execution

// ===== tb/branch_exec_checker.sv
`timescale 1ns/1ps
module branch_exec_checker (
	// Core side
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic [15:0] instr_word,
	input wire logic        instr_valid,
	input wire logic [4:0]  status_in,
	input wire logic [4:0]  status_out,
	input wire logic [20:0] pc_value,
	input wire logic        pc_write,
	input wire logic [1:0]  q_phase,
	input wire logic        flush_cycle,
	input wire logic        cycle_done,
	input wire logic        is_branch
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Flush follows a conditional branch exactly when its flag was clear
	property p_cond(logic [7:0] c, int b);
		q_phase == 2'h2 && $past(instr_valid && !flush_cycle, 2) && $past(instr_word[15:8], 2) == c
		|-> ##2 flush_cycle != $past(status_in[b], 2);
	endproperty
	a_status_copy: assert property (status_out == status_in) else $error("flag changed");
	a_phase_step: assert property (!$past(reset) |-> q_phase == $past(q_phase) + 2'h1)
		else $error("phase skipped");
	a_flush_len: assert property ($rose(flush_cycle) |-> flush_cycle[*4] ##1 !flush_cycle)
		else $error("bad no-op length");
	a_flush_start: assert property ($rose(flush_cycle) |-> q_phase == 2'h0 && pc_write)
		else $error("no-op misplaced");
	a_write_cause: assert property (pc_write |-> $rose(flush_cycle)) else $error("stray write");
	a_always_two: assert property (q_phase == 2'h0 && instr_valid && !flush_cycle
		&& instr_word[15:11] == 5'h1A |-> ##4 pc_write) else $error("always branch not taken");
	a_zero_cond: assert property (p_cond(8'hE1, 2)) else $error("zero test wrong");
	a_ovf_cond: assert property (p_cond(8'hE5, 3)) else $error("overflow test wrong");
	a_pc_moves: assert property ($changed(pc_value) |-> q_phase == 2'h2 || pc_write)
		else $error("counter moved off phase");
	a_done_phase: assert property (cycle_done == (q_phase == 2'h3))
		else $error("done strobe off phase");
	a_branch_seen: assert property (q_phase == 2'h1 && $past(instr_valid && !flush_cycle)
		&& ($past(instr_word[15:8]) == 8'hE1 || $past(instr_word[15:8]) == 8'hE5
		|| $past(instr_word[15:11]) == 5'h1A) |-> is_branch) else $error("branch not flagged");
	a_idle_quiet: assert property (q_phase == 2'h1 && !$past(instr_valid) |-> !is_branch)
		else $error("empty slot flagged");
	c_write: cover property (pc_write);
	c_noop: cover property ($rose(flush_cycle) ##4 !flush_cycle);
	c_untaken: cover property (q_phase == 2'h2 && !flush_cycle && status_in[2]);
endmodule : branch_exec_checker

// ===== tb/fetch_model.sv
`timescale 1ns/1ps
module fetch_model (
	// Bench side
	input wire logic        go,
	input wire logic [15:0] word,
	// Core side
	input wire logic [1:0]  q_phase,
	input wire logic        flush_cycle,
	output logic            instr_valid,
	output logic     [15:0] instr_word
);
	// Offer a word only in a fresh phase one, scramble the bus otherwise
	assign instr_valid = go && q_phase == 2'h0 && !flush_cycle;
	assign instr_word  = instr_valid ? word : ~word;
endmodule : fetch_model

// ===== tb/tb_relative_branch_execution.sv
`timescale 1ns/1ps
module tb_relative_branch_execution;
	import branch_exec_pkg::*;
	logic        core_clk, reset, go, instr_valid, pc_write, flush_cycle, t;
	logic [15:0] word, instr_word;
	logic [4:0]  status_in;
	logic [20:0] pc_value;
	logic [1:0]  q_phase;
	logic [21:0] notes[$];
	logic [15:0] tbl[4] = '{16'hE17F, 16'hE580, 16'hD3FF, 16'hD400};
	logic [7:0]  up[3] = '{8'hE1, 8'hE5, 8'hD0};
	pc_t         pc, o;
	int          errors, n_compared;
	bit          pend;
	relative_branch_execution i_relative_branch_execution(.core_clk(core_clk), .reset(reset),
		.instr_word(instr_word), .instr_valid(instr_valid), .status_in(status_in),
		.status_out(), .pc_value(pc_value), .pc_write(pc_write), .q_phase(q_phase),
		.flush_cycle(flush_cycle), .cycle_done(), .is_branch());
	fetch_model i_fetch_model(.go(go), .word(word), .q_phase(q_phase),
		.flush_cycle(flush_cycle), .instr_valid(instr_valid), .instr_word(instr_word));
	task check(input logic [21:0] seen, input logic [21:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task final_report;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	// Clock
	initial begin
		core_clk = 0;
		forever #2 core_clk = ~core_clk;
	end
	// Watchdog
	initial begin
		#8000;
		errors++;
		final_report();
	end
	// Check each instruction at the next phase one, no-op cycle included
	always @(negedge core_clk) if (!reset && q_phase == 2'h0) begin
		if (pend) check({pc_value, flush_cycle}, notes.pop_front());
		pend = instr_valid;
	end
	// Boundary offsets first, then random branches, flags and other words
	initial begin
		reset = 1;
		go = 0;
		word = 16'h0000;
		status_in = 5'h00;
		pc = 21'h000000;
		void'($urandom(61));
		repeat (12) @(posedge core_clk);
		#1 reset = 0;
		go = 1;
		for (int i = 0; i < 60; i++) begin
			while (!(q_phase == 2'h0 && !flush_cycle)) @(posedge core_clk) #1;
			word = 16'($urandom);
			if (i % 4 < 3) word[15:8] = up[i % 4] | {5'h00, word[10:8] & {3{i % 4 == 2}}};
			if (i < 4) word = tbl[i];
			status_in = i < 4 ? 5'h00 : 5'($urandom);
			t = word[15:11] == 5'h1A || word[15:8] == 8'hE1 && !status_in[2]
				|| word[15:8] == 8'hE5 && !status_in[3];
			o = word[15:11] == 5'h1A ? {{10{word[10]}}, word[10:0]} : {{13{word[7]}}, word[7:0]};
			pc = pc + 21'h000002 + (t ? o << 1 : 21'h000000);
			notes.push_back({pc, t});
			@(posedge core_clk) #1;
		end
		go = 0;
		repeat (12) @(posedge core_clk);
		final_report();
	end
endmodule : tb_relative_branch_execution
bind relative_branch_execution branch_exec_checker i_branch_exec_checker(.core_clk(core_clk),
	.reset(reset), .instr_word(instr_word), .instr_valid(instr_valid), .status_in(status_in),
	.status_out(status_out), .pc_value(pc_value), .pc_write(pc_write), .q_phase(q_phase),
	.flush_cycle(flush_cycle), .cycle_done(cycle_done), .is_branch(is_branch));
